// >>> rtl/fp_regs_defs.vh
// Constants for the floating-point status/control and unit-control registers.
// Included by fp_status_control_regs.v; definitions only.
`ifndef FP_REGS_DEFS_VH
`define FP_REGS_DEFS_VH

// Register select codes on the coprocessor move port
`define SEL_STATUS_CTRL   1'h0
`define SEL_UNIT_CTRL     1'h1

// Status/control field positions
`define SC_NEG            31
`define SC_ZERO           30
`define SC_CARRY          29
`define SC_OVFL           28
`define SC_SAT            27
`define SC_AHP            26
`define SC_DNAN           25
`define SC_FLUSH          24
`define SC_RND_HI         23
`define SC_RND_LO         22
`define SC_STR_HI         21
`define SC_STR_LO         20
`define SC_LEN_HI         18
`define SC_LEN_LO         16
`define SC_IDC            7
`define SC_EXC_HI         4
`define SC_EXC_LO         0

// Writable bits of status/control; reserved bits read as zero
`define SC_WMASK          32'hfff7009f

// Unit-control field positions
`define UC_ASYNC          31
`define UC_EN             30
`define UC_DEX            29

// Reset values
`define SC_RESET          32'h00000000
`define UC_RESET          3'h0
`define ZERO_WORD         32'h00000000
`define FLAG_CLEAR        1'h0
`define FLAG_SET          1'h1
`define COND_RESET        4'h0
`define STRIDE_RESET      2'h0
`define LEN_RESET         3'h0
`define EXC_RESET         6'h00
`define EXPORT_RESET      7'h00

// Index of each cumulative flag inside the six-flag group
`define EXC_IDX_IDC       5
`define EXC_IDX_HI        4
`define EXC_IDX_LO        0

// Rounding codes
`define RND_NEAREST       2'h0
`define RND_PLUS          2'h1
`define RND_MINUS         2'h2
`define RND_ZERO          2'h3

// Exported flag width: saturation, input denormal, five exception flags
`define EXPORT_W          7

`endif

// >>> rtl/fp_status_control_regs.v
// Status/control and unit-control registers of a floating-point/SIMD coprocessor.
// Assumes the core decodes coprocessor moves and supplies privilege, security and
// access-control state on the same clock; arithmetic units read the effective modes.
//
// Function
// - Comparison result writes less, equal, carry, unordered flags into bits 31..28.
// - Saturation bit 27 sets on SIMD saturation, stays until software writes zero.
// - Bit 26 picks IEEE half format at 0, alternative format at 1.
// - Bit 25 at 1 gives default NaN for scalar ops; 0 propagates NaNs.
// - SIMD arithmetic always uses default NaN regardless of bit 25.
// - Bit 24 at 1 enables scalar flush-to-zero; 0 gives full IEEE behaviour.
// - SIMD arithmetic always flushes to zero regardless of bit 24.
// - Bits 23:22 select scalar rounding: nearest, plus, minus, zero.
// - SIMD arithmetic always rounds to nearest.
// - Stride bits 21:20 are stored only and affect nothing.
// - Non-zero length field 18:16 makes scalar data-processing instructions trap.
// - Sticky exception flags at bits 7 and 4:0 accumulate until written.
// - Bits 27, 7 and 4:0 are driven continuously on an output port.
// - Unit-control bit 31 reads zero and ignores writes.
// - Unit-control bit 30 disables both extensions at 0, enables at 1.
// - Reset clears the enable bit.
// - Scalar op with non-zero length sets trap flag bit 29 and traps.
// - Reset clears the trap flag.
// - Unit-control access only privileged and with coprocessor 10/11 access enabled.
// - Non-secure unit-control access needs both non-secure permission bits set.
`timescale 1ns/1ps
`include "fp_regs_defs.vh"

module fp_status_control_regs (
  // Clock and reset
  input  wire                   clock,
  input  wire                   reset,
  // Coprocessor move port
  input  wire                   moveValid,
  input  wire                   moveWrite,
  input  wire                   moveSel,
  input  wire [31:0]            moveWdata,
  output reg  [31:0]            moveRdata,
  output reg                    moveDone,
  output reg                    moveUndef,
  // Core access state
  input  wire                   privileged,
  input  wire                   nonSecure,
  input  wire                   coprocTen,
  input  wire                   coprocEleven,
  input  wire                   nsCoprocTen,
  input  wire                   nsCoprocEleven,
  // Comparison result
  input  wire                   cmpValid,
  input  wire                   cmpLess,
  input  wire                   cmpEqual,
  input  wire                   cmpUnordered,
  // Arithmetic event reports
  input  wire                   satEvent,
  input  wire [`EXPORT_W-2:0]   excEvent,
  // Scalar instruction issue
  input  wire                   scalarIssue,
  output reg                    scalarTrap,
  // Effective modes for the arithmetic units
  output reg                    unitEnable,
  output reg                    altHalfFormatSel,
  output reg                    scalarDefaultNan,
  output reg                    scalarFlush,
  output reg  [1:0]             scalarRound,
  output reg                    simdDefaultNan,
  output reg                    simdFlush,
  output reg  [1:0]             simdRound,
  // Exported sticky flags
  output reg  [`EXPORT_W-1:0]   stickyFlagsOut
);

  // Move decode and effective request strobes
  wire        selStatus;
  wire        selUnit;
  wire        unitAccessOk;
  wire        statusAccessOk;
  wire        wrStatus;
  wire        wrUnit;
  wire        rdStatus;
  wire        rdUnit;
  wire        refused;
  wire [31:0] wdataMasked;
  wire        cmpTaken;
  wire        satTaken;
  wire [5:0]  excTaken;
  wire        lenNonZero;
  wire        trapNow;
  wire [31:0] statusCtrlRead;
  wire [31:0] unitCtrlRead;

  // Status/control fields
  reg  [3:0]  condFlags_reg;
  reg  [3:0]  condFlags_next;
  reg         satSticky_reg;
  reg         satSticky_next;
  reg         altHalf_reg;
  reg         altHalf_next;
  reg         defaultNan_reg;
  reg         defaultNan_next;
  reg         flush_reg;
  reg         flush_next;
  reg  [1:0]  round_reg;
  reg  [1:0]  round_next;
  reg  [1:0]  stride_reg;
  reg  [1:0]  stride_next;
  reg  [2:0]  vecLen_reg;
  reg  [2:0]  vecLen_next;
  reg  [5:0]  excSticky_reg;
  wire [5:0]  excSticky_next;

  // Unit-control fields
  reg         enable_reg;
  reg         enable_next;
  reg         syncTrap_reg;
  reg         syncTrap_next;

  // Coprocessor permission shared by both registers; non-secure callers
  // also need both non-secure permissions
  function coprocAllowed;
    input ten;
    input eleven;
    input ns;
    input nsTen;
    input nsEleven;
    begin
      coprocAllowed = ten & eleven & (~ns | (nsTen & nsEleven));
    end
  endfunction

  // Read view of the unit-control register
  function [31:0] unitView;
    input en;
    input sync_trap_flag;
    begin
      unitView = `ZERO_WORD;
      unitView[`UC_EN] = en;
      unitView[`UC_DEX] = sync_trap_flag;
    end
  endfunction

  // Read view of the status/control register; reserved bits stay zero
  function [31:0] statusView;
    input [3:0] cond;
    input       sat;
    input       alt_half_format_sel;
    input       dnan;
    input       fz;
    input [1:0] rnd;
    input [1:0] str;
    input [2:0] len;
    input [5:0] exc;
    begin
      statusView = `ZERO_WORD;
      statusView[`SC_NEG:`SC_OVFL] = cond;
      statusView[`SC_SAT] = sat;
      statusView[`SC_AHP] = alt_half_format_sel;
      statusView[`SC_DNAN] = dnan;
      statusView[`SC_FLUSH] = fz;
      statusView[`SC_RND_HI:`SC_RND_LO] = rnd;
      statusView[`SC_STR_HI:`SC_STR_LO] = str;
      statusView[`SC_LEN_HI:`SC_LEN_LO] = len;
      statusView[`SC_IDC] = exc[`EXC_IDX_IDC];
      statusView[`SC_EXC_HI:`SC_EXC_LO] = exc[`EXC_IDX_HI:`EXC_IDX_LO];
    end
  endfunction

  assign selStatus      = (moveSel == `SEL_STATUS_CTRL);
  assign selUnit        = (moveSel == `SEL_UNIT_CTRL);
  assign unitAccessOk   = privileged &
                          coprocAllowed(coprocTen, coprocEleven, nonSecure, nsCoprocTen, nsCoprocEleven);
  // Status access needs the unit enabled but not privilege
  assign statusAccessOk = enable_reg &
                          coprocAllowed(coprocTen, coprocEleven, nonSecure, nsCoprocTen, nsCoprocEleven);
  assign wrStatus       = moveValid & moveWrite & selStatus & statusAccessOk;
  assign wrUnit         = moveValid & moveWrite & selUnit & unitAccessOk;
  assign rdStatus       = moveValid & ~moveWrite & selStatus & statusAccessOk;
  assign rdUnit         = moveValid & ~moveWrite & selUnit & unitAccessOk;
  assign refused        = (selUnit & ~unitAccessOk) | (selStatus & ~statusAccessOk);
  assign wdataMasked    = moveWdata & `SC_WMASK;
  // Arithmetic reports are taken only while the unit is enabled
  assign cmpTaken       = cmpValid & enable_reg;
  assign satTaken       = satEvent & enable_reg;
  assign excTaken       = excEvent & {(`EXPORT_W-1){enable_reg}};
  assign lenNonZero     = |vecLen_reg;
  assign trapNow        = scalarIssue & enable_reg & lenNonZero;
  assign unitCtrlRead   = unitView(enable_reg, syncTrap_reg);
  assign statusCtrlRead = statusView(condFlags_reg, satSticky_reg, altHalf_reg, defaultNan_reg, flush_reg,
                                     round_reg, stride_reg, vecLen_reg, excSticky_reg);

  // Condition flags; a comparison overrides a same-cycle write
  always @* begin
    condFlags_next = condFlags_reg;
    if (wrStatus) begin
      condFlags_next = wdataMasked[`SC_NEG:`SC_OVFL];
    end
    if (cmpTaken) begin
      condFlags_next = {cmpLess, cmpEqual, ~cmpLess, cmpUnordered};
    end
  end

  // Saturation flag; saturation wins over a same-cycle clear
  always @* begin
    satSticky_next = satSticky_reg;
    if (wrStatus) begin
      satSticky_next = wdataMasked[`SC_SAT];
    end
    if (satTaken) begin
      satSticky_next = `FLAG_SET;
    end
  end

  // Mode and legacy fields change only by software writes
  always @* begin
    altHalf_next    = altHalf_reg;
    defaultNan_next = defaultNan_reg;
    flush_next      = flush_reg;
    round_next      = round_reg;
    stride_next     = stride_reg;
    vecLen_next     = vecLen_reg;
    if (wrStatus) begin
      altHalf_next    = wdataMasked[`SC_AHP];
      defaultNan_next = wdataMasked[`SC_DNAN];
      flush_next      = wdataMasked[`SC_FLUSH];
      round_next      = wdataMasked[`SC_RND_HI:`SC_RND_LO];
      stride_next     = wdataMasked[`SC_STR_HI:`SC_STR_LO];
      vecLen_next     = wdataMasked[`SC_LEN_HI:`SC_LEN_LO];
    end
  end

  // Cumulative exception flags; an event wins over a same-cycle clear
  genvar g;
  generate
    for (g = 0; g < `EXPORT_W-1; g = g + 1) begin : gen_exc_sticky
      localparam integer POS = (g == `EXC_IDX_IDC) ? `SC_IDC : (`SC_EXC_LO + g);
      assign excSticky_next[g] = (wrStatus ? wdataMasked[POS] : excSticky_reg[g]) | excTaken[g];
    end
  endgenerate

  // Unit-control fields; a trap wins over a same-cycle clear
  always @* begin
    enable_next   = enable_reg;
    syncTrap_next = syncTrap_reg;
    if (wrUnit) begin
      enable_next   = moveWdata[`UC_EN];
      syncTrap_next = moveWdata[`UC_DEX];
    end
    if (trapNow) begin
      syncTrap_next = `FLAG_SET;
    end
  end

  // Register state
  always @(posedge clock) begin
    if (reset) begin
      condFlags_reg  <= `COND_RESET;
      satSticky_reg  <= `FLAG_CLEAR;
      altHalf_reg    <= `FLAG_CLEAR;
      defaultNan_reg <= `FLAG_CLEAR;
      flush_reg      <= `FLAG_CLEAR;
      round_reg      <= `RND_NEAREST;
      stride_reg     <= `STRIDE_RESET;
      vecLen_reg     <= `LEN_RESET;
      excSticky_reg  <= `EXC_RESET;
      enable_reg     <= `FLAG_CLEAR;
      syncTrap_reg   <= `FLAG_CLEAR;
    end else begin
      condFlags_reg  <= condFlags_next;
      satSticky_reg  <= satSticky_next;
      altHalf_reg    <= altHalf_next;
      defaultNan_reg <= defaultNan_next;
      flush_reg      <= flush_next;
      round_reg      <= round_next;
      stride_reg     <= stride_next;
      vecLen_reg     <= vecLen_next;
      excSticky_reg  <= excSticky_next;
      enable_reg     <= enable_next;
      syncTrap_reg   <= syncTrap_next;
    end
  end

  // Move answer one cycle after the request; refused moves read zero
  always @(posedge clock) begin
    if (reset) begin
      moveRdata <= `ZERO_WORD;
      moveDone  <= `FLAG_CLEAR;
      moveUndef <= `FLAG_CLEAR;
    end else begin
      moveDone  <= moveValid;
      moveUndef <= moveValid & refused;
      if (rdUnit) begin
        moveRdata <= unitCtrlRead;
      end else if (rdStatus) begin
        moveRdata <= statusCtrlRead;
      end else begin
        moveRdata <= `ZERO_WORD;
      end
    end
  end

  // Scalar modes, enable and exported flags follow the next register values; SIMD modes are constant
  always @(posedge clock) begin
    if (reset) begin
      scalarTrap       <= `FLAG_CLEAR;
      unitEnable       <= `FLAG_CLEAR;
      altHalfFormatSel <= `FLAG_CLEAR;
      scalarDefaultNan <= `FLAG_CLEAR;
      scalarFlush      <= `FLAG_CLEAR;
      scalarRound      <= `RND_NEAREST;
      simdDefaultNan   <= `FLAG_SET;
      simdFlush        <= `FLAG_SET;
      simdRound        <= `RND_NEAREST;
      stickyFlagsOut   <= `EXPORT_RESET;
    end else begin
      scalarTrap       <= trapNow;
      unitEnable       <= enable_next;
      altHalfFormatSel <= altHalf_next;
      scalarDefaultNan <= defaultNan_next;
      scalarFlush      <= flush_next;
      scalarRound      <= round_next;
      simdDefaultNan   <= `FLAG_SET;
      simdFlush        <= `FLAG_SET;
      simdRound        <= `RND_NEAREST;
      stickyFlagsOut   <= {satSticky_next, excSticky_next};
    end
  end

endmodule // fp_status_control_regs

// >>> verif/fp_regs_chk.sv
// Port-level checker for the floating-point status and unit-control register bank.
// Assumes one clock and a synchronous active-high reset; bound into the design below.
`timescale 1ns/1ps
module fp_regs_chk (
  // Clock, reset and move port
  input wire        clock,
  input wire        reset,
  input wire        moveValid,
  input wire        moveWrite,
  input wire        moveSel,
  input wire [31:0] moveRdata,
  input wire        moveUndef,
  // Access state
  input wire        privileged,
  input wire        nonSecure,
  input wire        coprocTen,
  input wire        coprocEleven,
  input wire        nsCoprocTen,
  input wire        nsCoprocEleven,
  // Events and modes
  input wire        satEvent,
  input wire        scalarIssue,
  input wire        scalarTrap,
  input wire        unitEnable,
  input wire        simdDefaultNan,
  input wire        simdFlush,
  input wire [1:0]  simdRound,
  input wire [6:0]  stickyFlagsOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence unitRead;
    moveValid && !moveWrite && moveSel && privileged && coprocTen && coprocEleven && !nonSecure;
  endsequence
  chk_unit_read: assert property (unitRead |=> !moveUndef && !moveRdata[31] && moveRdata[30] == $past(unitEnable))
    else $error("unit read data wrong");
  chk_unit_refuse: assert property (moveValid && moveSel && !privileged |=> moveUndef && moveRdata == 32'h0)
    else $error("unprivileged unit access not refused");
  chk_ns_refuse: assert property (moveValid && moveSel && nonSecure && !(nsCoprocTen && nsCoprocEleven) |=> moveUndef)
    else $error("non-secure unit access not refused");
  chk_status_off: assert property (moveValid && !moveSel && !unitEnable |=> moveUndef)
    else $error("status access while disabled");
  chk_sat_sets: assert property (satEvent && unitEnable |=> stickyFlagsOut[6])
    else $error("saturation flag not set");
  chk_sticky_hold: assert property (!(moveValid && moveWrite && !moveSel) |=> ($past(stickyFlagsOut) & ~stickyFlagsOut) == 7'h0)
    else $error("sticky flag fell without write");
  chk_simd_modes: assert property (simdDefaultNan && simdFlush && simdRound == 2'h0)
    else $error("simd modes not fixed");
  chk_trap_cause: assert property (scalarTrap |-> $past(scalarIssue) && $past(unitEnable))
    else $error("trap without enabled issue");
endmodule // fp_regs_chk
bind fp_status_control_regs fp_regs_chk u_chk (.*);

// >>> verif/fp_status_control_regs_test.sv
// Self-checking bench for the floating-point register bank.
// Drives the move port, access state and event pulses directly.
`timescale 1ns/1ps
module fp_status_control_regs_test;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg         moveValid = 1'b0;
  reg         moveWrite = 1'b0;
  reg         moveSel = 1'b0;
  reg  [31:0] moveWdata = 32'h0;
  reg  [5:0]  acc = 6'h2f;   // Privileged, non-secure, coproc ten/eleven, ns ten/eleven
  reg  [11:0] evs = 12'h0;   // Issue, sat, unordered, equal, less, compare, six exception flags
  wire [31:0] moveRdata;
  wire        moveDone, moveUndef, scalarTrap, unitEnable, altHalf, sDn, sFz, vDn, vFz;
  wire [1:0]  sRnd, vRnd;
  wire [6:0]  flags;
  reg  [31:0] rd;
  reg         ud;
  integer     nErrors = 0, numChecks = 0, i;
  always #5 clock = ~clock;
  fp_status_control_regs dut (
    .clock(clock), .reset(reset), .moveValid(moveValid), .moveWrite(moveWrite), .moveSel(moveSel),
    .moveWdata(moveWdata), .moveRdata(moveRdata), .moveDone(moveDone), .moveUndef(moveUndef),
    .privileged(acc[5]), .nonSecure(acc[4]), .coprocTen(acc[3]), .coprocEleven(acc[2]),
    .nsCoprocTen(acc[1]), .nsCoprocEleven(acc[0]), .cmpValid(evs[6]), .cmpLess(evs[7]),
    .cmpEqual(evs[8]), .cmpUnordered(evs[9]), .satEvent(evs[10]), .excEvent(evs[5:0]),
    .scalarIssue(evs[11]), .scalarTrap(scalarTrap), .unitEnable(unitEnable), .altHalfFormatSel(altHalf),
    .scalarDefaultNan(sDn), .scalarFlush(sFz), .scalarRound(sRnd), .simdDefaultNan(vDn),
    .simdFlush(vFz), .simdRound(vRnd), .stickyFlagsOut(flags));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        nErrors = nErrors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d errors=%0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task mv(input w, input s, input [31:0] d);
    integer k;
    begin
      @(posedge clock);
      moveValid <= 1'b1;
      moveWrite <= w;
      moveSel <= s;
      moveWdata <= d;
      @(posedge clock);
      moveValid <= 1'b0;
      #1;
      for (k = 0; k < 4 && moveDone !== 1'b1; k = k + 1) @(posedge clock) #1;
      if (moveDone !== 1'b1) begin
        nErrors = nErrors + 1;
        give_verdict;
      end
      rd = moveRdata;
      ud = moveUndef;
    end
  endtask
  // One event pulse, sampled just after the edge that takes it
  task ev(input [11:0] v);
    begin
      @(posedge clock);
      evs <= v;
      @(posedge clock);
      evs <= 12'h0;
      #1;
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    mv(0, 1, 32'h0);
    chk(rd, 32'h0);
    chk({flags, unitEnable}, 32'h0);
    mv(0, 0, 32'h0);
    chk(ud, 1'b1);
    $display("test reset done");
    mv(1, 1, 32'hffffffff);
    mv(0, 1, 32'h0);
    chk(rd, 32'h60000000);
    mv(1, 1, 32'h40000000);
    mv(1, 0, 32'hffffffff);
    mv(0, 0, 32'h0);
    chk(rd, 32'hfff7009f);
    chk({altHalf, sDn, sFz, vDn, vFz, vRnd}, 32'h7c);
    for (i = 0; i < 4; i = i + 1) begin
      mv(1, 0, i << 22);
      chk(sRnd, i);
    end
    chk(flags, 32'h0);
    $display("test masks done");
    ev(12'h43f);
    chk(flags, 32'h7f);
    mv(0, 0, 32'h0);
    chk(rd, 32'h08c0009f);
    for (i = 0; i < 3; i = i + 1) begin
      ev(12'h040 | (12'h080 << i));
      mv(0, 0, 32'h0);
      chk(rd[31:28], (32'h368 >> (4 * i)) & 32'hf);
    end
    $display("test events done");
    mv(1, 0, 32'h00010000);
    ev(12'h800);
    chk(scalarTrap, 1'b1);
    mv(0, 1, 32'h0);
    chk(rd, 32'h60000000);
    mv(1, 1, 32'h40000000);
    mv(1, 0, 32'h0);
    ev(12'h800);
    chk(scalarTrap, 1'b0);
    $display("test trap done");
    @(posedge clock) acc <= 6'h0f;
    mv(0, 1, 32'h0);
    chk(ud, 32'h1);
    chk(rd, 32'h0);
    @(posedge clock) acc <= 6'h3e;
    mv(0, 1, 32'h0);
    chk(ud, 1'b1);
    @(posedge clock) acc <= 6'h3f;
    mv(0, 1, 32'h0);
    chk(rd, 32'h40000000);
    mv(1, 1, 32'h0);
    ev(12'h400);
    mv(1, 1, 32'h40000000);
    chk(flags, 32'h0);
    $display("test access done");
    give_verdict;
  end
endmodule // fp_status_control_regs_test
